// ===== logic/a429_device_end.sv
`timescale 1ns/1ps
module a429_device_end import a429_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Host port
   a429_host_if.device hp,
   // Words from the line decoders
   input wire logic [1:0][31:0] rxWord,
   input wire logic [1:0] rxWordStrobe,
   // Serial transmit line
   output logic txLineA,
   output logic txLineB,
   output logic txClkOut
);
   // ---------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------
   logic [7:0] pinSync1_ff;
   logic [7:0] pinSync2_ff;
   logic [7:0] pinPrev_ff;
   logic [15:0] dataSync1_ff;
   logic [15:0] dataSync2_ff;
   logic [15:0] ldData_ff;

   wire logic [7:0] pinRaw = {hp.masterResetN, hp.rxOutputEnableN, hp.halfSel, hp.txEnable,
                              hp.txHighHalfLoadN, hp.txLowHalfLoadN, hp.ctrlWordLoadN};

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pinSync1_ff <= PIN_RESET;
         pinSync2_ff <= PIN_RESET;
         pinPrev_ff <= PIN_RESET;
         dataSync1_ff <= '0;
         dataSync2_ff <= '0;
      end
      else
      begin
         pinSync1_ff <= pinRaw;
         pinSync2_ff <= pinSync1_ff;
         pinPrev_ff <= pinSync2_ff;
         dataSync1_ff <= hp.dataBus;
         dataSync2_ff <= dataSync1_ff;
      end
   end

   wire logic [7:0] rises = pinSync2_ff & ~pinPrev_ff;
   wire logic [7:0] falls = ~pinSync2_ff & pinPrev_ff;
   wire logic mrActive = !pinSync2_ff[P_MR];
   wire logic txEnOn = pinSync2_ff[P_EN];
   wire logic selHigh = pinSync2_ff[P_SEL];
   wire logic [1:0] oeFall = falls[6:5];
   wire logic [1:0] oeLow = ~pinSync2_ff[6:5];
   wire logic anyLoadLow = !(pinSync2_ff[P_CW] && pinSync2_ff[P_LO] && pinSync2_ff[P_HI]);

   // Bus is sampled while a strobe is low; zero hold time forbids using it after the rise
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ldData_ff <= '0;
      else if (anyLoadLow)
         ldData_ff <= dataSync2_ff;
   end

   // ---------------------------------------------
   // Control word
   // ---------------------------------------------
   logic [15:0] ctrl_ff;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ctrl_ff <= CW_RESET;
      else if (mrActive)
         ctrl_ff <= CW_RESET;
      else if (rises[P_CW])
         ctrl_ff <= ldData_ff;
   end

   wire logic rateLo = ctrl_ff[CW_RATE_LO_BIT];
   wire logic word25 = ctrl_ff[CW_WORD25_BIT];
   wire logic parEn = ctrl_ff[CW_PAR_EN_BIT];
   wire logic parEven = ctrl_ff[CW_PAR_EVEN_BIT];

   // ---------------------------------------------
   // Transmit buffer
   // ---------------------------------------------
   logic [31:0] txMem [TX_DEPTH];
   logic [15:0] lowHalf_ff;
   logic [3:0] wrCnt_ff;
   logic [3:0] rdCnt_ff;
   logic txEmpty_ff;

   wire logic loWrite = rises[P_LO] && !txEnOn && !mrActive;
   wire logic hiWrite = rises[P_HI] && !txEnOn && !mrActive;
   // A load into a full buffer overwrites the last entry
   wire logic [2:0] wrIdx = (wrCnt_ff == TX_FULL) ? 3'h7 : wrCnt_ff[2:0];

   always_ff @(posedge clk)
   begin
      if (hiWrite)
         txMem[wrIdx] <= {ldData_ff, lowHalf_ff};
   end

   // ---------------------------------------------
   // Bit clock divider
   // ---------------------------------------------
   logic [10:0] halfCnt_ff;
   logic txClk_ff;

   wire logic halfTick = halfCnt_ff == 11'h000;
   wire logic [10:0] halfReload = rateLo ? HALF_LO_CNT : HALF_HI_CNT;
   wire logic bitStart = halfTick && !txClk_ff;
   wire logic midBit = halfTick && txClk_ff;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         halfCnt_ff <= HALF_HI_CNT;
         txClk_ff <= 1'b0;
      end
      else
      begin
         halfCnt_ff <= halfTick ? halfReload : halfCnt_ff - 11'h001;
         txClk_ff <= halfTick ? !txClk_ff : txClk_ff;
      end
   end

   // ---------------------------------------------
   // Serialiser
   // ---------------------------------------------
   logic [31:0] shift_ff;
   logic [5:0] bitsLeft_ff;
   logic [2:0] gapLeft_ff;
   logic lineA_ff;
   logic lineB_ff;

   wire logic [31:0] rawWord = txMem[rdCnt_ff[2:0]];
   wire logic [31:0] dataMask = word25 ? 32'h00ff_ffff : 32'h7fff_ffff;
   wire logic [31:0] parMask = word25 ? 32'h0100_0000 : 32'h8000_0000;
   wire logic parBit = (^(rawWord & dataMask)) ^ !parEven;
   wire logic [31:0] txWord = parEn ? ((rawWord & dataMask) | (parBit ? parMask : 32'h0)) : rawWord;
   wire logic [5:0] wordLen = word25 ? WORD_SHORT : WORD_LONG;
   wire logic idle = bitsLeft_ff == 6'h00;
   wire logic haveWord = rdCnt_ff != wrCnt_ff;
   wire logic startWord = bitStart && idle && gapLeft_ff == 3'h0 && txEnOn && haveWord;
   // Block ends on the null half of its last bit, so the flag stays close to the word's end
   wire logic blockDone = midBit && idle && !haveWord && wrCnt_ff != 4'h0 && !hiWrite;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shift_ff <= '0;
         bitsLeft_ff <= '0;
         gapLeft_ff <= '0;
         lineA_ff <= 1'b0;
         lineB_ff <= 1'b0;
         wrCnt_ff <= '0;
         rdCnt_ff <= '0;
         lowHalf_ff <= '0;
         txEmpty_ff <= 1'b1;
      end
      else if (mrActive)
      begin
         bitsLeft_ff <= '0;
         gapLeft_ff <= '0;
         lineA_ff <= 1'b0;
         lineB_ff <= 1'b0;
         wrCnt_ff <= '0;
         rdCnt_ff <= '0;
         txEmpty_ff <= 1'b1;
      end
      else
      begin
         if (loWrite)
            lowHalf_ff <= ldData_ff;
         if (hiWrite)
         begin
            txEmpty_ff <= 1'b0;
            if (wrCnt_ff != TX_FULL)
               wrCnt_ff <= wrCnt_ff + 4'h1;
         end
         if (startWord)
         begin
            lineA_ff <= txWord[0];
            lineB_ff <= !txWord[0];
            shift_ff <= txWord >> 1;
            bitsLeft_ff <= wordLen - 6'h01;
            rdCnt_ff <= rdCnt_ff + 4'h1;
         end
         else if (bitStart && !idle)
         begin
            lineA_ff <= shift_ff[0];
            lineB_ff <= !shift_ff[0];
            shift_ff <= shift_ff >> 1;
            bitsLeft_ff <= bitsLeft_ff - 6'h01;
            if (bitsLeft_ff == 6'h01)
               gapLeft_ff <= GAP_BITS;
         end
         else if (bitStart && gapLeft_ff != 3'h0)
            gapLeft_ff <= gapLeft_ff - 3'h1;
         if (midBit)
         begin
            lineA_ff <= 1'b0;
            lineB_ff <= 1'b0;
         end
         if (blockDone)
         begin
            txEmpty_ff <= 1'b1;
            wrCnt_ff <= '0;
            rdCnt_ff <= '0;
         end
      end
   end

   assign txLineA = lineA_ff;
   assign txLineB = lineB_ff;
   assign txClkOut = txClk_ff;
   assign hp.txBufferEmpty = txEmpty_ff;

   // ---------------------------------------------
   // Receive holding registers
   // ---------------------------------------------
   logic [15:0] rxHalf [2];
   wire logic [1:0] readyNVec;

   for (genvar c = 0; c < 2; c++)
   begin : g_rx
      logic [31:0] pend_ff;
      logic [31:0] hold_ff;
      logic pendValid_ff;
      logic readyN_ff;
      logic firstRead_ff;

      always_ff @(posedge clk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            pend_ff <= '0;
            hold_ff <= '0;
            pendValid_ff <= 1'b0;
            readyN_ff <= 1'b1;
            firstRead_ff <= 1'b0;
         end
         else if (mrActive)
         begin
            pendValid_ff <= 1'b0;
            readyN_ff <= 1'b1;
            firstRead_ff <= 1'b0;
         end
         else
         begin
            // Unread hold register is never overwritten; newer words replace the pending one
            if (rxWordStrobe[c])
               pend_ff <= rxWord[c];
            pendValid_ff <= rxWordStrobe[c] || (pendValid_ff && !readyN_ff);
            if (readyN_ff && pendValid_ff)
            begin
               hold_ff <= pend_ff;
               readyN_ff <= 1'b0;
            end
            else if (oeFall[c] && !readyN_ff)
            begin
               if (!selHigh)
                  firstRead_ff <= 1'b1;
               else if (firstRead_ff)
               begin
                  readyN_ff <= 1'b1;
                  firstRead_ff <= 1'b0;
               end
            end
         end
      end

      assign rxHalf[c] = selHigh ? hold_ff[31:16] : hold_ff[15:0];
      assign readyNVec[c] = readyN_ff;
   end

   assign hp.rxWordReadyN = readyNVec;

   // ---------------------------------------------
   // Read data onto the bus
   // ---------------------------------------------
   logic [15:0] devData_ff;
   logic devOeN_ff;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         devData_ff <= '0;
         devOeN_ff <= 1'b1;
      end
      else
      begin
         devData_ff <= oeLow[0] ? rxHalf[0] : rxHalf[1];
         devOeN_ff <= oeLow == 2'b00;
      end
   end

   assign hp.devData = devData_ff;
   assign hp.devDataOeN = devOeN_ff;
endmodule

// ===== logic/a429_host_end.sv
`timescale 1ns/1ps
module a429_host_end import a429_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Device port
   a429_host_if.host hp,
   // Configuration
   input wire logic [15:0] ctrlWord,
   // Words to transmit
   input wire logic [31:0] txWord,
   input wire logic txWordValid,
   output logic txWordReady,
   // Received words
   output logic [31:0] rxWord,
   output logic rxChan,
   output logic rxWordValid,
   input wire logic rxWordReady
);
   typedef enum logic [2:0] {
      H_RESET = 3'h0,
      H_CTRL = 3'h1,
      H_IDLE = 3'h2,
      H_LDLO = 3'h3,
      H_LDHI = 3'h4,
      H_RDLO = 3'h5,
      H_RDHI = 3'h6,
      H_WAIT = 3'h7
   } host_state_e;

   host_state_e state_ff;
   host_state_e after_ff;
   logic [7:0] tmr_ff;
   logic [4:0] strobeN_ff;
   logic [2:0] sync1_ff;
   logic [2:0] sync2_ff;
   logic [15:0] dSync1_ff;
   logic [15:0] dSync2_ff;
   logic mrN_ff;
   logic txEn_ff;
   logic sel_ff;
   logic chan_ff;
   logic [15:0] hData_ff;
   logic hOeN_ff;
   logic [31:0] word_ff;
   logic [3:0] words_ff;
   logic txReady_ff;
   logic push_ff;
   wire logic fifoReady;

   // ---------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1_ff <= 3'h7;
         sync2_ff <= 3'h7;
         dSync1_ff <= '0;
         dSync2_ff <= '0;
      end
      else
      begin
         sync1_ff <= {hp.txBufferEmpty, hp.rxWordReadyN};
         sync2_ff <= sync1_ff;
         dSync1_ff <= hp.dataBus;
         dSync2_ff <= dSync1_ff;
      end
   end

   wire logic emptyS = sync2_ff[2];
   wire logic [1:0] readyS = ~sync2_ff[1:0];

   // ---------------------------------------------
   // Strobe shaping
   // ---------------------------------------------
   wire logic isOe = state_ff == H_RDLO || state_ff == H_RDHI;
   wire logic [7:0] stSetup = isOe ? OE_SETUP_CYC : LD_SETUP_CYC;
   wire logic [7:0] stEnd = stSetup + (isOe ? OE_PW_CYC : LD_PW_CYC);
   wire logic [4:0] stMask = state_ff == H_CTRL ? 5'h01 : state_ff == H_LDLO ? 5'h02 :
                             state_ff == H_LDHI ? 5'h04 : chan_ff ? 5'h10 : 5'h08;
   // A block in progress keeps loading although the device has already dropped empty
   wire logic canLoad = (emptyS || words_ff != 4'h0) && !txEn_ff && words_ff != TX_FULL &&
                        readyS == 2'b00;
   wire logic take = state_ff == H_IDLE && txWordValid && txReady_ff;
   wire logic stLast = tmr_ff == stEnd - 8'h01;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff <= H_RESET;
         after_ff <= H_IDLE;
         tmr_ff <= '0;
         strobeN_ff <= STROBES_IDLE;
         mrN_ff <= 1'b0;
         txEn_ff <= 1'b0;
         sel_ff <= 1'b0;
         chan_ff <= 1'b0;
         hData_ff <= '0;
         hOeN_ff <= 1'b1;
         word_ff <= '0;
         words_ff <= '0;
         txReady_ff <= 1'b0;
         push_ff <= 1'b0;
      end
      else
      begin
         tmr_ff <= tmr_ff + 8'h01;
         push_ff <= 1'b0;
         txReady_ff <= state_ff == H_IDLE && !take && canLoad;
         unique case (state_ff)
            H_RESET:
               if (tmr_ff == MR_PW_CYC - 8'h01)
               begin
                  mrN_ff <= 1'b1;
                  tmr_ff <= '0;
                  after_ff <= H_CTRL;
                  state_ff <= H_WAIT;
               end
            H_IDLE:
            begin
               tmr_ff <= '0;
               if (take)
               begin
                  word_ff <= txWord;
                  hData_ff <= txWord[15:0];
                  hOeN_ff <= 1'b0;
                  state_ff <= H_LDLO;
               end
               else if (readyS != 2'b00 && fifoReady)
               begin
                  chan_ff <= !readyS[0];
                  sel_ff <= 1'b0;
                  state_ff <= H_RDLO;
               end
               else if (words_ff != 4'h0 && !(txWordValid && words_ff != TX_FULL))
               begin
                  txEn_ff <= 1'b1;
                  words_ff <= '0;
                  after_ff <= H_IDLE;
                  state_ff <= H_WAIT;
               end
               else if (txEn_ff && emptyS)
                  txEn_ff <= 1'b0;
            end
            H_WAIT:
               if (tmr_ff == GAP_CYC - 8'h01)
               begin
                  tmr_ff <= '0;
                  state_ff <= after_ff;
                  if (after_ff == H_CTRL)
                  begin
                     hData_ff <= ctrlWord;
                     hOeN_ff <= 1'b0;
                  end
               end
            default:
            begin
               // Select is held through the whole strobe and into the wait; data changes or is released on the edge that ends the strobe
               if (tmr_ff == stSetup - 8'h01)
                  strobeN_ff <= ~stMask;
               if (stLast)
               begin
                  strobeN_ff <= STROBES_IDLE;
                  tmr_ff <= '0;
                  state_ff <= H_WAIT;
                  after_ff <= H_IDLE;
                  unique case (state_ff)
                     H_CTRL:
                        hOeN_ff <= 1'b1;
                     H_LDLO:
                     begin
                        hData_ff <= word_ff[31:16];
                        after_ff <= H_LDHI;
                     end
                     H_LDHI:
                     begin
                        hOeN_ff <= 1'b1;
                        words_ff <= words_ff + 4'h1;
                     end
                     H_RDLO:
                     begin
                        word_ff[15:0] <= dSync2_ff;
                        after_ff <= H_RDHI;
                     end
                     default:
                     begin
                        word_ff[31:16] <= dSync2_ff;
                        push_ff <= 1'b1;
                     end
                  endcase
               end
               if (state_ff == H_RDHI && tmr_ff == 8'h00)
                  sel_ff <= 1'b1;
            end
         endcase
      end
   end

   assign hp.masterResetN = mrN_ff;
   assign hp.ctrlWordLoadN = strobeN_ff[0];
   assign hp.txLowHalfLoadN = strobeN_ff[1];
   assign hp.txHighHalfLoadN = strobeN_ff[2];
   assign hp.rxOutputEnableN = strobeN_ff[4:3];
   assign hp.txEnable = txEn_ff;
   assign hp.halfSel = sel_ff;
   assign hp.hostData = hData_ff;
   assign hp.hostDataOeN = hOeN_ff;
   assign txWordReady = txReady_ff;

   // ---------------------------------------------
   // Received word buffer
   // ---------------------------------------------
   // Space is checked before a read starts, so the single push is never refused
   pair_fifo #(
      .WIDTH(33),
      .DEPTH(2)
   ) u_rx_buf (
      .clk(clk),
      .rst_n(rst_n),
      .inValid(push_ff),
      .inReady(fifoReady),
      .inData({chan_ff, word_ff}),
      .outValid(rxWordValid),
      .outReady(rxWordReady),
      .outData({rxChan, rxWord})
   );
endmodule

// ===== logic/a429_host_if.sv
`timescale 1ns/1ps
interface a429_host_if;
   logic masterResetN;
   logic ctrlWordLoadN;
   logic txLowHalfLoadN;
   logic txHighHalfLoadN;
   logic txEnable;
   logic txBufferEmpty;
   logic [1:0] rxWordReadyN;
   logic [1:0] rxOutputEnableN;
   logic halfSel;
   logic [15:0] hostData;
   logic hostDataOeN;
   logic [15:0] devData;
   logic devDataOeN;
   wire logic [15:0] dataBus;

   // Undriven bus reads as all ones, like a pulled-up bus
   assign dataBus = !hostDataOeN ? hostData : (!devDataOeN ? devData : 16'hffff);

   modport device (
      input masterResetN, ctrlWordLoadN, txLowHalfLoadN, txHighHalfLoadN, txEnable,
      input rxOutputEnableN, halfSel, dataBus,
      output txBufferEmpty, rxWordReadyN, devData, devDataOeN
   );
   modport host (
      output masterResetN, ctrlWordLoadN, txLowHalfLoadN, txHighHalfLoadN, txEnable,
      output rxOutputEnableN, halfSel, hostData, hostDataOeN,
      input txBufferEmpty, rxWordReadyN, dataBus
   );
endinterface

// ===== logic/a429_pkg.sv
package a429_pkg;

   // ---------------------------------------------
   // Clock and serial timing
   // ---------------------------------------------
   localparam int CLK_NS = 25;
   localparam int HALF_HI_NS = 5000;
   localparam int HALF_LO_NS = 40000;
   localparam int HALF_HI_CYC = HALF_HI_NS / CLK_NS;
   localparam int HALF_LO_CYC = HALF_LO_NS / CLK_NS;
   localparam logic [10:0] HALF_HI_CNT = 11'(HALF_HI_CYC - 1);
   localparam logic [10:0] HALF_LO_CNT = 11'(HALF_LO_CYC - 1);
   localparam logic [2:0] GAP_BITS = 3'h4;
   localparam logic [5:0] WORD_LONG = 6'h20;
   localparam logic [5:0] WORD_SHORT = 6'h19;
   localparam int TX_DEPTH = 8;
   localparam logic [3:0] TX_FULL = 4'h8;

   // ---------------------------------------------
   // Control word fields
   // ---------------------------------------------
   localparam int CW_RATE_LO_BIT = 0;
   localparam int CW_WORD25_BIT = 1;
   localparam int CW_PAR_EN_BIT = 2;
   localparam int CW_PAR_EVEN_BIT = 3;
   localparam logic [15:0] CW_RESET = 16'h0000;

   // ---------------------------------------------
   // Pin sampling and reset values
   // ---------------------------------------------
   localparam int P_CW = 0;
   localparam int P_LO = 1;
   localparam int P_HI = 2;
   localparam int P_EN = 3;
   localparam int P_SEL = 4;
   localparam int P_MR = 7;
   localparam logic [7:0] PIN_RESET = 8'h67;
   localparam logic [4:0] STROBES_IDLE = 5'h1f;

   // ---------------------------------------------
   // Host strobe timing
   // ---------------------------------------------
   localparam int LD_SETUP_NS = 110;
   localparam int LD_PW_NS = 130;
   localparam int OE_SETUP_NS = 20;
   localparam int OE_PW_NS = 200;
   localparam int MR_PW_NS = 500;
   localparam int GAP_NS = 300;
   localparam logic [7:0] LD_SETUP_CYC = 8'((LD_SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] LD_PW_CYC = 8'((LD_PW_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] OE_SETUP_CYC = 8'((OE_SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] OE_PW_CYC = 8'((OE_PW_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] MR_PW_CYC = 8'((MR_PW_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] GAP_CYC = 8'((GAP_NS + CLK_NS - 1) / CLK_NS);

endpackage

// ===== logic/pair_fifo.sv
`timescale 1ns/1ps
module pair_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wrPtr_ff;
   logic [PW-1:0] rdPtr_ff;
   logic [CW-1:0] count_ff;

   wire logic push = inValid && inReady;
   wire logic pop = outValid && outReady;
   wire logic wrLast = wrPtr_ff == PW'(DEPTH - 1);
   wire logic rdLast = rdPtr_ff == PW'(DEPTH - 1);

   assign inReady = count_ff != CW'(DEPTH);
   assign outValid = count_ff != '0;
   assign outData = mem[rdPtr_ff];

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wrPtr_ff] <= inData;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
      end
      else
      begin
         if (push)
            wrPtr_ff <= wrLast ? '0 : wrPtr_ff + PW'(1);
         if (pop)
            rdPtr_ff <= rdLast ? '0 : rdPtr_ff + PW'(1);
         count_ff <= count_ff + CW'(push) - CW'(pop);
      end
   end
endmodule

// ===== tb/a429_monitor.sv
`timescale 1ns/1ps
module a429_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Host port
   input wire logic masterResetN,
   input wire logic ctrlWordLoadN,
   input wire logic txLowHalfLoadN,
   input wire logic txHighHalfLoadN,
   input wire logic txEnable,
   input wire logic txBufferEmpty,
   input wire logic [1:0] rxWordReadyN,
   input wire logic [1:0] rxOutputEnableN,
   input wire logic halfSel,
   input wire logic hostDataOeN,
   input wire logic devDataOeN
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // ------
   // Checks
   // ------
   chk_bus_no_fight: assert property (hostDataOeN || devDataOeN)
      else $error("bus driven by both ends");
   chk_reset_quiet: assert property (
      !masterResetN |-> &{ctrlWordLoadN, txLowHalfLoadN, txHighHalfLoadN, rxOutputEnableN})
      else $error("strobe during master reset");
   chk_load_disabled: assert property (
      !(txLowHalfLoadN && txHighHalfLoadN) |-> !txEnable)
      else $error("load while enabled");
   chk_empty_drops: assert property (
      $rose(txHighHalfLoadN) && txBufferEmpty |-> ##[1:8] !txBufferEmpty)
      else $error("empty flag stuck high");
   chk_one_reader: assert property (rxOutputEnableN != 2'b00)
      else $error("two receivers read at once");
   chk_sel_stable: assert property (
      rxOutputEnableN != 2'b11 && $past(rxOutputEnableN) != 2'b11 |-> $stable(halfSel))
      else $error("half select moved in read");
   chk_read_when_ready: assert property (
      $fell(rxOutputEnableN[0]) |-> !rxWordReadyN[0])
      else $error("read without ready word");
   chk_ready_release: assert property (
      $fell(rxOutputEnableN[1]) && halfSel |-> ##[1:8] rxWordReadyN[1])
      else $error("ready not released");
   cover property ($fell(txBufferEmpty));
   cover property ($rose(rxWordReadyN[1]));
   cover property ($fell(rxOutputEnableN[0]) && halfSel);
endmodule

// ===== tb/arinc429_host_port_tb_top.sv
`timescale 1ns/1ps
module arinc429_host_port_tb_top import a429_pkg::*;;
   logic clk = 0, rst_n = 0, txLineA, txLineB, rxChan, rxWordValid, txWordReady;
   logic [1:0][31:0] devRxWord = '0;
   logic [1:0] devRxStrobe = 2'h0;
   logic [31:0] txWord = 32'h0, rxWord;
   logic txWordValid = 0, rxWordReady = 0;
   int failures = 0, checksDone = 0, cycles = 0;
   a429_host_if hp ();
   a429_device_end a429_device_end_inst (.clk(clk), .rst_n(rst_n), .hp(hp.device),
      .rxWord(devRxWord), .rxWordStrobe(devRxStrobe), .txLineA(txLineA),
      .txLineB(txLineB), .txClkOut());
   a429_host_end a429_host_end_inst (.clk(clk), .rst_n(rst_n), .hp(hp.host),
      .ctrlWord(16'h0000), .txWord(txWord), .txWordValid(txWordValid),
      .txWordReady(txWordReady), .rxWord(rxWord), .rxChan(rxChan),
      .rxWordValid(rxWordValid), .rxWordReady(rxWordReady));
   a429_monitor mon (.clk(clk), .rst_n(rst_n), .masterResetN(hp.masterResetN),
      .ctrlWordLoadN(hp.ctrlWordLoadN), .txLowHalfLoadN(hp.txLowHalfLoadN),
      .txHighHalfLoadN(hp.txHighHalfLoadN), .txEnable(hp.txEnable),
      .txBufferEmpty(hp.txBufferEmpty), .rxWordReadyN(hp.rxWordReadyN),
      .rxOutputEnableN(hp.rxOutputEnableN), .halfSel(hp.halfSel),
      .hostDataOeN(hp.hostDataOeN), .devDataOeN(hp.devDataOeN));
   always #12.5 clk = ~clk;
   // ------------
   // Shared tasks
   // ------------
   task test_done();
      $display("checks %0d failures %0d", checksDone, failures);
      if (failures == 0 && checksDone > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task compare(input logic [32:0] got, input logic [32:0] exp);
      checksDone++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task strobe();
      @(posedge clk);
      #1 devRxStrobe = 2'h3;
      @(posedge clk);
      #1 devRxStrobe = 2'h0;
   endtask
   task read_word(input logic [32:0] exp);
      for (int n = 0; n < 400 && rxWordValid !== 1'b1; n++) @(negedge clk);
      compare({rxChan, rxWord}, exp);
      @(posedge clk);
      #1;
   endtask
   // Samples mid data half and mid null half of every bit
   task serial(input logic [31:0] w, input int bound);
      int n;
      for (n = 0; n < bound && !(txLineA || txLineB); n++) @(negedge clk);
      compare(33'(n < bound), 33'h1);
      for (int i = 0; i < 32; i++)
      begin
         repeat (HALF_HI_CYC / 2) @(negedge clk);
         compare(33'({txLineA, txLineB}), 33'({w[i], !w[i]}));
         repeat (HALF_HI_CYC) @(negedge clk);
         compare(33'({txLineA, txLineB}), 33'h0);
         repeat (HALF_HI_CYC / 2) @(negedge clk);
      end
   endtask
   // ---------
   // Scenarios
   // ---------
   // Second pair lands while the buffer is full and reading stalls
   task test_rx();
      devRxWord = {32'h5a5a_0002, 32'ha5a5_0001};
      strobe();
      repeat (300) @(posedge clk);
      devRxWord = {32'h8765_4321, 32'h1234_5678};
      strobe();
      repeat (300) @(posedge clk);
      #1 rxWordReady = 1;
      read_word({1'b0, 32'ha5a5_0001});
      read_word({1'b1, 32'h5a5a_0002});
      read_word({1'b0, 32'h1234_5678});
      read_word({1'b1, 32'h8765_4321});
      rxWordReady = 0;
      $display("rx test done");
   endtask
   task test_tx();
      txWord = 32'hc3a5_5a3c;
      txWordValid = 1;
      for (int n = 0; n < 2000 && txWordReady !== 1'b1; n++) @(negedge clk);
      @(posedge clk);
      #1 txWord = 32'h8000_0001;
      for (int n = 0; n < 2000 && txWordReady !== 1'b1; n++) @(negedge clk);
      @(posedge clk);
      #1 txWordValid = 0;
      for (int n = 0; n < 2000 && hp.txEnable !== 1'b1; n++) @(negedge clk);
      serial(32'hc3a5_5a3c, 1000);
      compare(33'(hp.txBufferEmpty), 33'h0);
      repeat (7 * HALF_HI_CYC - HALF_HI_CYC / 2) @(negedge clk);
      compare(33'({txLineA, txLineB}), 33'h0);
      repeat (HALF_HI_CYC + HALF_HI_CYC / 2 - 10) @(negedge clk);
      serial(32'h8000_0001, 20);
      compare(33'(hp.txBufferEmpty), 33'h1);
      $display("tx test done");
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         failures++;
         test_done();
      end
   end
   initial
   begin
      repeat (10) @(posedge clk);
      #1 rst_n = 1;
      repeat (100) @(posedge clk);
      #1;
      test_rx();
      test_tx();
      test_done();
   end
endmodule
